/* File: hw/opsp_top.sv */
// Implementation choice: strobed register access.
`include "opsp_map.svh"
`default_nettype none
// What this block does
// - indicator 0 selector routes eight functions
// - remap bit turns indicator 1 into tx-error input
// - divide bit halves the selected clock
// - source codes 0000-0111 pick base clocks
// - codes 1000-1011 pick mode, rmii, serdes clocks
// - code 1100 picks 30 ns tick
// - inversion bit inverts the selected clock
// - clock pin selector routes eight functions
// - daisy-chain strap forces clock pin selector zero
// - strap sets clock pin selector reset value
// - rx pull code: none, up, down
// - bit 13 enables forced rx pulls
// - tx pull code: none, up, down
// - bit 10 enables forced tx pulls
// - rx pad impedance code drives rx pads
// - tx pad impedance code drives tx pads
module opsp_top import opsp_pkg::*; (
  // clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_arst_n,
  // register port
  input  wire logic [`OPSP_ADDR_W-1:0]  i_addr,
  input  wire logic [`OPSP_DATA_W-1:0]  i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [`OPSP_DATA_W-1:0]  o_rdata,
  // straps
  input  wire logic                     i_receive_data3_config_strap,
  input  wire logic                     i_ind1_daisy_strap,
  // pin functions
  input  wire logic                     i_link_ind,
  input  wire logic                     i_ind0_clkmux,
  input  wire logic                     i_ind1_func,
  input  wire logic                     i_wake_on_lan_event,
  input  wire logic                     i_undervolt,
  input  wire logic                     i_ptp_tx_evt,
  input  wire logic                     i_ptp_rx_evt,
  input  wire logic                     i_esd_evt,
  input  wire logic                     i_irq,
  // clock sources
  input  wire logic [7:0]               i_clk_src_lo,
  input  wire logic                     i_rmii_mode,
  input  wire logic                     i_ref_clk_50,
  input  wire logic                     i_ref_clk_25,
  input  wire logic [6:0]               i_clk_src_hi,
  // indicator 1 pin
  input  wire logic                     i_ind1_pin_in,
  output logic                          o_ind1_oe,
  output logic                          o_mac_tx_err,
  // muxed pins
  output logic                          o_ind0,
  output logic                          o_clk_pin,
  // mac pads
  input  wire logic [1:0]               i_rx_pull_norm,
  input  wire logic [1:0]               i_tx_pull_norm,
  output logic      [1:0]               o_rx_pull,
  output logic      [1:0]               o_tx_pull,
  output logic      [4:0]               o_rx_imp,
  output logic      [4:0]               o_tx_imp
);

  //////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_q;
  logic rst_sync_q;
  wire  rst_sync_n = rst_sync_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  logic       strap_done_q;
  logic       txer_q;
  logic       div_q;
  logic [3:0] src_q;
  logic       inv_q;
  logic [2:0] pin_sel_q;
  logic [2:0] pin_sel_d;
  logic [`OPSP_DATA_W-1:0] pad_q;
  logic [2:0] ind0_sel_q;

  wire wr_clk  = i_wr && (i_addr == `OPSP_ADDR_CLK_PIN);
  wire wr_pad  = i_wr && (i_addr == `OPSP_ADDR_PAD);
  wire wr_ind0 = i_wr && (i_addr == `OPSP_ADDR_IND0);

  wire [2:0] strap_sel = i_receive_data3_config_strap ? `OPSP_PINSEL_STRAP
                                                      : `OPSP_PINSEL_RST;
  wire [2:0] wr_sel    = i_wdata[`OPSP_CLK_SEL_HI:`OPSP_CLK_SEL_LO];

  always_comb begin
    pin_sel_d = pin_sel_q;
    if (!strap_done_q) pin_sel_d = strap_sel;
    else if (wr_clk)   pin_sel_d = wr_sel;
    if (i_ind1_daisy_strap) pin_sel_d = `OPSP_PINSEL_DAISY;
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      strap_done_q <= 1'b0;
      pin_sel_q    <= `OPSP_PINSEL_RST;
    end else begin
      strap_done_q <= 1'b1;
      pin_sel_q    <= pin_sel_d;
    end
  end

  // reserved field bits are never stored
  always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      txer_q <= 1'b0;
      div_q  <= 1'b0;
      src_q  <= `OPSP_SRC_RST;
      inv_q  <= 1'b0;
    end else if (wr_clk) begin
      txer_q <= i_wdata[`OPSP_CLK_TXER_BIT];
      div_q  <= i_wdata[`OPSP_CLK_DIV_BIT];
      src_q  <= i_wdata[`OPSP_CLK_SRC_HI:`OPSP_CLK_SRC_LO];
      inv_q  <= i_wdata[`OPSP_CLK_INV_BIT];
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_q      <= `OPSP_PAD_RST;
      ind0_sel_q <= `OPSP_IND0_RST;
    end else begin
      if (wr_pad)  pad_q      <= i_wdata;
      if (wr_ind0) ind0_sel_q <= i_wdata[`OPSP_IND0_SEL_HI:`OPSP_IND0_SEL_LO];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read back
  wire [`OPSP_DATA_W-1:0] clk_word  = {txer_q, {`OPSP_CLK_RSV_W{1'b0}}, div_q, src_q,
                                       inv_q, pin_sel_q};
  wire [`OPSP_DATA_W-1:0] ind0_word = {{`OPSP_IND0_PAD_W{1'b0}}, ind0_sel_q};
  wire [`OPSP_DATA_W-1:0] rd_word   =
      (i_addr == `OPSP_ADDR_CLK_PIN) ? clk_word  :
      (i_addr == `OPSP_ADDR_PAD)     ? pad_q     :
      (i_addr == `OPSP_ADDR_IND0)    ? ind0_word : `OPSP_PAD_RST;
  wire [`OPSP_DATA_W-1:0] rdata_d   = i_rd ? rd_word : `OPSP_PAD_RST;

  logic [`OPSP_DATA_W-1:0] rdata_q;
  always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) rdata_q <= `OPSP_PAD_RST;
    else             rdata_q <= rdata_d;
  end
  assign o_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // clock source and pin muxes
  opsp_clk_if clk_link ();
  opsp_pin_if ind0_link ();
  opsp_pin_if cpin_link ();

  wire mode_dependent_ref_clock = i_rmii_mode ? i_ref_clk_50 : i_ref_clk_25;

  assign clk_link.src  = {i_clk_src_hi, mode_dependent_ref_clock, i_clk_src_lo};
  assign clk_link.code = src_q;
  assign clk_link.div  = div_q;
  assign clk_link.inv  = inv_q;

  wire [7:0] ind0_func = {i_irq, i_esd_evt, i_ptp_rx_evt, i_ptp_tx_evt, i_undervolt,
                          i_wake_on_lan_event, i_ind0_clkmux, i_link_ind};
  wire [7:0] cpin_func = {i_irq, i_esd_evt, i_ptp_rx_evt, i_ptp_tx_evt, i_undervolt,
                          i_wake_on_lan_event, clk_link.out, i_ind1_func};

  assign ind0_link.func = ind0_func;
  assign ind0_link.sel  = ind0_sel_q;
  assign cpin_link.func = cpin_func;
  assign cpin_link.sel  = pin_sel_q;
  assign o_ind0         = ind0_link.out;
  assign o_clk_pin      = cpin_link.out;

  opsp_clk_sel u_clk_sel (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_sync_n),
    .clk        (clk_link)
  );

  opsp_out_mux u_ind0_mux (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_sync_n),
    .pin        (ind0_link)
  );

  opsp_out_mux u_cpin_mux (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_sync_n),
    .pin        (cpin_link)
  );

  //////////////////////////////////////////////////////////////////////////////
  // indicator 1 remap and pads
  logic       ind1_oe_q;
  logic       tx_err_q;
  logic [1:0] rx_pull_q;
  logic [1:0] tx_pull_q;
  logic [4:0] rx_imp_q;
  logic [4:0] tx_imp_q;

  wire [1:0] rx_val   = pad_q[`OPSP_PAD_RXV_HI:`OPSP_PAD_RXV_LO];
  wire [1:0] tx_val   = pad_q[`OPSP_PAD_TXV_HI:`OPSP_PAD_TXV_LO];
  wire [1:0] rx_force = (rx_val == OPSP_PULL_RSVD) ? OPSP_PULL_NONE : rx_val;
  wire [1:0] tx_force = (tx_val == OPSP_PULL_RSVD) ? OPSP_PULL_NONE : tx_val;
  wire [1:0] rx_pull_d = pad_q[`OPSP_PAD_RXF_BIT] ? rx_force : i_rx_pull_norm;
  wire [1:0] tx_pull_d = pad_q[`OPSP_PAD_TXF_BIT] ? tx_force : i_tx_pull_norm;

  always_ff @(posedge i_core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ind1_oe_q <= 1'b1;
      tx_err_q  <= 1'b0;
      rx_pull_q <= OPSP_PULL_NONE;
      tx_pull_q <= OPSP_PULL_NONE;
      rx_imp_q  <= 5'h00;
      tx_imp_q  <= 5'h00;
    end else begin
      ind1_oe_q <= ~txer_q;
      tx_err_q  <= txer_q & i_ind1_pin_in;
      rx_pull_q <= rx_pull_d;
      tx_pull_q <= tx_pull_d;
      rx_imp_q  <= pad_q[`OPSP_PAD_RXI_HI:`OPSP_PAD_RXI_LO];
      tx_imp_q  <= pad_q[`OPSP_PAD_TXI_HI:`OPSP_PAD_TXI_LO];
    end
  end

  assign o_ind1_oe    = ind1_oe_q;
  assign o_mac_tx_err = tx_err_q;
  assign o_rx_pull    = rx_pull_q;
  assign o_tx_pull    = tx_pull_q;
  assign o_rx_imp     = rx_imp_q;
  assign o_tx_imp     = tx_imp_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  // registers leave reset one edge after the synchronised release
  default disable iff (!strap_done_q);

  ind0_route_a: assert property (
    1'b1 |=> o_ind0 == $past(ind0_func[ind0_sel_q]))
    else $error("indicator 0 shows wrong function");

  txer_remap_a: assert property (
    txer_q |=> (!o_ind1_oe && o_mac_tx_err == $past(i_ind1_pin_in)))
    else $error("indicator 1 not turned into tx error input");

  clkpin_route_a: assert property (
    1'b1 |=> o_clk_pin == $past(cpin_func[pin_sel_q]))
    else $error("clock pin shows wrong function");

  daisy_force_a: assert property (
    i_ind1_daisy_strap |=> pin_sel_q == `OPSP_PINSEL_DAISY)
    else $error("daisy strap did not clear clock pin selector");

  strap_reset_a: assert property (
    (!strap_done_q && !i_ind1_daisy_strap) |=>
      pin_sel_q == ($past(i_receive_data3_config_strap) ? `OPSP_PINSEL_STRAP
                                                        : `OPSP_PINSEL_RST))
    else $error("strap reset value wrong");

  rx_pull_a: assert property (
    pad_q[`OPSP_PAD_RXF_BIT] && rx_val == OPSP_PULL_DOWN |=> o_rx_pull == OPSP_PULL_DOWN)
    else $error("forced rx pull not applied");

  tx_pull_a: assert property (
    !pad_q[`OPSP_PAD_TXF_BIT] |=> o_tx_pull == $past(i_tx_pull_norm))
    else $error("tx pull forced while disabled");

  pad_imp_a: assert property (
    wr_pad |=> ##1 (o_rx_imp == $past(i_wdata[`OPSP_PAD_RXI_HI:`OPSP_PAD_RXI_LO], 2)
                && o_tx_imp == $past(i_wdata[`OPSP_PAD_TXI_HI:`OPSP_PAD_TXI_LO], 2)))
    else $error("pad impedance code not applied");

  rsv_zero_a: assert property (
    (i_rd && i_addr == `OPSP_ADDR_CLK_PIN) |=>
      o_rdata[`OPSP_CLK_RSV_HI:`OPSP_CLK_RSV_LO] == '0)
    else $error("reserved bits read nonzero");

  cov_clkmux_c: cover property (pin_sel_q == OPSP_FN_CLKMUX && div_q && inv_q);
  cov_txer_c:   cover property (txer_q ##1 o_mac_tx_err);
  cov_rdpad_c:  cover property (i_rd && i_addr == `OPSP_ADDR_PAD ##1 o_rdata != '0);

endmodule : opsp_top
`default_nettype wire

/* File: hw/opsp_map.svh */
`ifndef OPSP_MAP_SVH
`define OPSP_MAP_SVH

// register addresses
`define OPSP_ADDR_W          12
`define OPSP_DATA_W          16
`define OPSP_ADDR_CLK_PIN    12'h453
`define OPSP_ADDR_PAD        12'h456
`define OPSP_ADDR_IND0       12'h460

// clock-pin configuration fields
`define OPSP_CLK_TXER_BIT    15
`define OPSP_CLK_RSV_HI      14
`define OPSP_CLK_RSV_LO      9
`define OPSP_CLK_RSV_W       6
`define OPSP_CLK_DIV_BIT     8
`define OPSP_CLK_SRC_HI      7
`define OPSP_CLK_SRC_LO      4
`define OPSP_CLK_INV_BIT     3
`define OPSP_CLK_SEL_HI      2
`define OPSP_CLK_SEL_LO      0

// pad pull / impedance fields
`define OPSP_PAD_RXV_HI      15
`define OPSP_PAD_RXV_LO      14
`define OPSP_PAD_RXF_BIT     13
`define OPSP_PAD_TXV_HI      12
`define OPSP_PAD_TXV_LO      11
`define OPSP_PAD_TXF_BIT     10
`define OPSP_PAD_RXI_HI      9
`define OPSP_PAD_RXI_LO      5
`define OPSP_PAD_TXI_HI      4
`define OPSP_PAD_TXI_LO      0

// indicator-0 selector register
`define OPSP_IND0_SEL_HI     2
`define OPSP_IND0_SEL_LO     0
`define OPSP_IND0_PAD_W      13

// reset values
`define OPSP_PINSEL_RST      3'h1
`define OPSP_PINSEL_STRAP    3'h0
`define OPSP_PINSEL_DAISY    3'h0
`define OPSP_PAD_RST         16'h0000
`define OPSP_IND0_RST        3'h0
`define OPSP_SRC_RST         4'h0

`endif

/* File: hw/opsp_pkg.sv */
`default_nettype none
package opsp_pkg;

  typedef enum logic [1:0] {
    OPSP_PULL_NONE = 2'b00,
    OPSP_PULL_UP   = 2'b01,
    OPSP_PULL_DOWN = 2'b10,
    OPSP_PULL_RSVD = 2'b11
  } opsp_pull_t;

  typedef enum logic [2:0] {
    OPSP_FN_PRIMARY = 3'b000,
    OPSP_FN_CLKMUX  = 3'b001,
    OPSP_FN_WOL     = 3'b010,
    OPSP_FN_UV      = 3'b011,
    OPSP_FN_PTP_TX  = 3'b100,
    OPSP_FN_PTP_RX  = 3'b101,
    OPSP_FN_ESD     = 3'b110,
    OPSP_FN_IRQ     = 3'b111
  } opsp_pin_func_t;

  typedef enum logic [3:0] {
    OPSP_SRC_XTAL     = 4'b0000,
    OPSP_SRC_PLL200   = 4'b0001,
    OPSP_SRC_ADC67    = 4'b0010,
    OPSP_SRC_FREE200  = 4'b0011,
    OPSP_SRC_MII25    = 4'b0100,
    OPSP_SRC_PLLREF   = 4'b0101,
    OPSP_SRC_CORE100  = 4'b0110,
    OPSP_SRC_DSP67    = 4'b0111,
    OPSP_SRC_MODEREF  = 4'b1000,
    OPSP_SRC_RMII_RX  = 4'b1001,
    OPSP_SRC_SER      = 4'b1010,
    OPSP_SRC_DES      = 4'b1011,
    OPSP_SRC_TICK30   = 4'b1100,
    OPSP_SRC_TICK40   = 4'b1101,
    OPSP_SRC_DLL_TX   = 4'b1110,
    OPSP_SRC_DLL_RX   = 4'b1111
  } opsp_clk_src_t;

endpackage : opsp_pkg
`default_nettype wire

/* File: hw/opsp_links_if.sv */
`default_nettype none
interface opsp_pin_if;
  logic [7:0] func;
  logic [2:0] sel;
  logic       out;
  modport mux (input func, input sel, output out);
  modport top (output func, output sel, input out);
endinterface : opsp_pin_if

interface opsp_clk_if;
  logic [15:0] src;
  logic [3:0]  code;
  logic        div;
  logic        inv;
  logic        out;
  modport sel (input src, input code, input div, input inv, output out);
  modport top (output src, output code, output div, output inv, input out);
endinterface : opsp_clk_if
`default_nettype wire

/* File: hw/opsp_out_mux.sv */
`include "opsp_map.svh"
`default_nettype none
module opsp_out_mux import opsp_pkg::*; (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // selector link
  opsp_pin_if.mux  pin
);

  logic out_q;
  wire  chosen = pin.func[pin.sel];

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) out_q <= 1'b0;
    else          out_q <= chosen;
  end

  assign pin.out = out_q;

endmodule : opsp_out_mux
`default_nettype wire

/* File: hw/opsp_clk_sel.sv */
`include "opsp_map.svh"
`default_nettype none
module opsp_clk_sel import opsp_pkg::*; (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // source selection link
  opsp_clk_if.sel  clk
);

  logic prev_q;
  logic tog_q;
  logic out_q;
  logic live_q;

  wire src_now  = clk.src[clk.code];
  wire src_rise = src_now & ~prev_q;
  wire base     = clk.div ? tog_q : src_now;
  wire out_d    = base ^ clk.inv;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 1'b0;
      tog_q  <= 1'b0;
      out_q  <= 1'b0;
      live_q <= 1'b0;
    end else begin
      prev_q <= src_now;
      tog_q  <= tog_q ^ src_rise;
      out_q  <= out_d;
      live_q <= 1'b1;
    end
  end

  assign clk.out = out_q;

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_core_clk); endclocking
  // flops leave reset one edge after the release
  default disable iff (!live_q);

  src_direct_a: assert property (
    !clk.div |=> out_q == ($past(src_now) ^ $past(clk.inv)))
    else $error("clock source or inversion mismatch");

  div_toggle_a: assert property (
    src_rise |=> tog_q != $past(tog_q))
    else $error("divider did not toggle on source edge");

  high_codes_a: assert property (
    (!clk.div && clk.code == OPSP_SRC_MODEREF) |=> out_q == ($past(clk.src[8]) ^ $past(clk.inv)))
    else $error("mode reference clock not routed");

  tick_code_a: assert property (
    (!clk.div && clk.code == OPSP_SRC_TICK30) |=> out_q == ($past(clk.src[12]) ^ $past(clk.inv)))
    else $error("30 ns tick not routed");

  cov_div_c: cover property (clk.div && src_rise ##1 tog_q);

endmodule : opsp_clk_sel
`default_nettype wire

/* File: testbench/tb_output_pin_select_pad_ctrl.sv */
`include "opsp_map.svh"
`default_nettype none
module tb_output_pin_select_pad_ctrl import opsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic                    i_core_clk = 1'b0;
  logic                    i_arst_n   = 1'b0;
  logic                    i_wr       = 1'b0;
  logic                    i_rd       = 1'b0;
  logic [`OPSP_ADDR_W-1:0] i_addr     = '0;
  logic [`OPSP_DATA_W-1:0] i_wdata    = '0;
  logic [`OPSP_DATA_W-1:0] o_rdata;
  logic                    strap      = 1'b0;
  logic                    daisy      = 1'b0;
  logic [7:0]              fn         = '0;
  logic                    ind1_func  = 1'b0;
  logic [7:0]              src_lo     = '0;
  logic [6:0]              src_hi     = '0;
  logic                    rmii       = 1'b0;
  logic                    r50        = 1'b0;
  logic                    r25        = 1'b0;
  logic                    pin_in     = 1'b0;
  logic [1:0]              rxn        = '0;
  logic [1:0]              txn        = '0;
  logic                    oe;
  logic                    txerr;
  logic                    ind0;
  logic                    clkpin;
  logic [1:0]              rxp;
  logic [1:0]              txp;
  logic [4:0]              rxi;
  logic [4:0]              txi;
  int                      num_errors      = 0;
  int                      samples_checked = 0;
  logic [15:0]             corner [4] = '{16'hFFFF, 16'h0000, 16'hA400, 16'h6C00};

  always #50 i_core_clk = ~i_core_clk;

  opsp_top i_dut (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_receive_data3_config_strap(strap), .i_ind1_daisy_strap(daisy),
    .i_link_ind(fn[0]), .i_ind0_clkmux(fn[1]), .i_ind1_func(ind1_func),
    .i_wake_on_lan_event(fn[2]), .i_undervolt(fn[3]), .i_ptp_tx_evt(fn[4]),
    .i_ptp_rx_evt(fn[5]), .i_esd_evt(fn[6]), .i_irq(fn[7]),
    .i_clk_src_lo(src_lo), .i_rmii_mode(rmii), .i_ref_clk_50(r50), .i_ref_clk_25(r25),
    .i_clk_src_hi(src_hi), .i_ind1_pin_in(pin_in), .o_ind1_oe(oe), .o_mac_tx_err(txerr),
    .o_ind0(ind0), .o_clk_pin(clkpin), .i_rx_pull_norm(rxn), .i_tx_pull_norm(txn),
    .o_rx_pull(rxp), .o_tx_pull(txp), .o_rx_imp(rxi), .o_tx_imp(txi)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic exp_src(input logic [3:0] c);
    if (c < 4'h8) return src_lo[c[2:0]];
    if (c == 4'h8) return rmii ? r50 : r25;
    return src_hi[3'(c - 4'h9)];
  endfunction : exp_src

  function automatic logic [1:0] exp_pull(input logic f, input logic [1:0] v, input logic [1:0] n);
    if (!f) return n;
    return (v == 2'b11) ? 2'b00 : v;
  endfunction : exp_pull

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected level at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic settle();
    repeat (3) @(posedge i_core_clk);
    #1;
  endtask : settle

  task automatic do_reset(input logic s, input logic dz);
    @(posedge i_core_clk);
    i_arst_n <= 1'b0;
    strap    <= s;
    daisy    <= dz;
    repeat (5) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    repeat (5) @(posedge i_core_clk);
  endtask : do_reset

  // counts pin changes while source bit 0 toggles every cycle
  task automatic count_edges(output int cnt);
    logic prev;
    cnt = 0;
    prev = clkpin;
    repeat (40) begin
      @(posedge i_core_clk);
      src_lo[0] <= ~src_lo[0];
      #1;
      if (clkpin !== prev) cnt++;
      prev = clkpin;
    end
  endtask : count_edges

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(2_000_000);
    num_errors++;
    test_done();
  end

  initial begin
    logic [15:0] d;
    logic [15:0] q;
    int          cnt;
    void'($urandom(32'h5666));
    do_reset(1'b0, 1'b0);
    rd(`OPSP_ADDR_CLK_PIN, d);
    check_word(d, 16'h0001);
    rd(`OPSP_ADDR_PAD, d);
    check_word(d, `OPSP_PAD_RST);
    do_reset(1'b1, 1'b0);
    rd(`OPSP_ADDR_CLK_PIN, d);
    check_word(d, 16'h0000);
    do_reset(1'b0, 1'b1);
    wr(`OPSP_ADDR_CLK_PIN, 16'h0105);
    rd(`OPSP_ADDR_CLK_PIN, d);
    check_word(d, 16'h0100);
    do_reset(1'b0, 1'b0);
    $display("test reset_straps done");

    wr(`OPSP_ADDR_CLK_PIN, 16'hFFFF);
    rd(`OPSP_ADDR_CLK_PIN, d);
    check_word(d, 16'h81FF);
    wr(12'h123, 16'hFFFF);
    rd(12'h123, d);
    check_word(d, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_core_clk);
      pin_in <= 1'(i);
      settle();
      check_bit(oe, 1'b0);
      check_bit(txerr, pin_in);
    end
    wr(`OPSP_ADDR_CLK_PIN, 16'h0001);
    settle();
    check_bit(oe, 1'b1);
    check_bit(txerr, 1'b0);
    $display("test reserved_remap done");

    for (int k = 0; k < 8; k++) begin
      wr(`OPSP_ADDR_IND0, 16'(k));
      wr(`OPSP_ADDR_CLK_PIN, (k == 1) ? 16'h0000 : 16'(k));
      repeat (3) begin
        @(posedge i_core_clk);
        fn        <= 8'($urandom);
        ind1_func <= 1'($urandom);
        settle();
        check_bit(ind0, fn[k]);
        check_bit(clkpin, (k < 2) ? ind1_func : fn[k]);
      end
    end
    $display("test pin_functions done");

    for (int c = 0; c < 16; c++) begin
      for (int inv = 0; inv < 2; inv++) begin
        wr(`OPSP_ADDR_CLK_PIN, {8'h00, 4'(c), 1'(inv), 3'b001});
        @(posedge i_core_clk);
        src_lo <= 8'($urandom);
        src_hi <= 7'($urandom);
        rmii   <= 1'($urandom);
        r50    <= 1'($urandom);
        r25    <= 1'($urandom);
        settle();
        check_bit(clkpin, exp_src(4'(c)) ^ 1'(inv));
      end
    end
    $display("test clock_sources done");

    // source parked low; divided path (three flops) delays the first pin change by three cycles, the undivided two-flop path by two
    @(posedge i_core_clk);
    src_lo <= '0;
    wr(`OPSP_ADDR_CLK_PIN, 16'h0101);
    settle();
    count_edges(cnt);
    check_word(16'(cnt), 16'h0013);
    wr(`OPSP_ADDR_CLK_PIN, 16'h0001);
    settle();
    count_edges(cnt);
    check_word(16'(cnt), 16'h0026);
    $display("test clock_divide done");

    for (int i = 0; i < 24; i++) begin
      d = (i < 4) ? corner[i] : 16'($urandom);
      @(posedge i_core_clk);
      rxn <= 2'($urandom);
      txn <= 2'($urandom);
      wr(`OPSP_ADDR_PAD, d);
      settle();
      check_word({11'h000, rxi}, {11'h000, d[9:5]});
      check_word({11'h000, txi}, {11'h000, d[4:0]});
      check_word({14'h0000, rxp}, {14'h0000, exp_pull(d[13], d[15:14], rxn)});
      check_word({14'h0000, txp}, {14'h0000, exp_pull(d[10], d[12:11], txn)});
      rd(`OPSP_ADDR_PAD, q);
      check_word(q, d);
    end
    $display("test pad_control done");
    test_done();
  end
endmodule : tb_output_pin_select_pad_ctrl
`default_nettype wire
